// file: rtl/arc_pkg.sv
// Constants shared by the converter result and clock select block
// What this block does
// - Result bits 9..2 go to bits 7..0 of the pair's high register
// - Result bits 1..0 go to bits 7..6 of the pair's low register
// - Channels 2 and 6 share the pair at F304 low, F305 high
// - Channels 3 and 7 share the pair at F306 low, F307 high
// - Low bit 0 flags a stored result; reading either half clears it
// - Two-bit select divides system clock by 2, 4, 8; 11 reserved; resets 00
// - Conversion steps count the selected conversion clock; a start or abort acts on the next system clock
// - One conversion takes exactly 86 conversion clocks until stored
package arc_pkg;

   // ----------------------------------------------------------------
   // Register indices (word address on the bus = index)
   // ----------------------------------------------------------------
   localparam logic [31:0] IDX_CLK_SEL = 32'hFFFFEE04;
   localparam logic [31:0] IDX_RES_LO_26 = 32'hFFFFF304;
   localparam logic [31:0] IDX_RES_HI_26 = 32'hFFFFF305;
   localparam logic [31:0] IDX_RES_LO_37 = 32'hFFFFF306;
   localparam logic [31:0] IDX_RES_HI_37 = 32'hFFFFF307;
   localparam logic [31:0] IDX_CONV_CTRL = 32'hFFFFF310;
   localparam logic [31:0] IDX_IRQ_STAT = 32'hFFFFF311;
   localparam logic [31:0] IDX_IRQ_MASK = 32'hFFFFF312;

   // ----------------------------------------------------------------
   // Field positions and fixed bit values
   // ----------------------------------------------------------------
   localparam int FLD_FLAG = 0;
   localparam int FLD_LO_RES = 6;
   localparam int FLD_START = 0;
   localparam int FLD_PAIR = 1;
   localparam logic [4:0] LO_FILL = 5'h1F;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;

   // ----------------------------------------------------------------
   // Reset values and counts
   // ----------------------------------------------------------------
   localparam logic [1:0] CLK_SEL_RST = 2'h0;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;
   localparam int CONV_CLOCKS = 86;
   localparam int RESULT_BITS = 10;
   localparam int PAIR_COUNT = 2;

   // Conversion clock divider codes
   typedef enum logic [1:0] {
      ARC_DIV2 = 2'b00,
      ARC_DIV4 = 2'b01,
      ARC_DIV8 = 2'b10,
      ARC_DIVR = 2'b11
   } arc_div_e;

   // Bus handshake states
   typedef enum logic [1:0] {
      ARC_BUS_IDLE = 2'b00,
      ARC_BUS_LOOK = 2'b01,
      ARC_BUS_ACK = 2'b10
   } arc_bus_e;

endpackage

// file: rtl/arc_result_store.sv
// Small result memory with registered read data
`timescale 1ns/1ps
module arc_result_store #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 2
) (
   input wire logic clk_i,
   input wire logic wr_en_i,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] mem_q [DEPTH];

   if (DEPTH < 2 || WIDTH < 1) begin : g_chk
      $error("arc_result_store: DEPTH must be 2 or more");
   end

   // No reset: contents are undefined until the first conversion
   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem_q[rd_addr_i];
   end

endmodule // arc_result_store

// file: rtl/arc_adc_result_clk.sv
// Converter result registers, stored flags and conversion clock select
`timescale 1ns/1ps
module arc_adc_result_clk #(
   parameter int DATA_W = 10,
   parameter int CONV_LEN = 86
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic [31:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [DATA_W-1:0] sar_data_i,
   output logic conv_clk_o,
   output logic conv_busy_o,
   output logic irq_o
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   localparam int CW = $clog2(CONV_LEN);

   if (DATA_W != arc_pkg::RESULT_BITS) begin : g_chk_w
      $error("arc_adc_result_clk: DATA_W must be 10");
   end
   if (CONV_LEN < 2 || CONV_LEN > 1024) begin : g_chk_len
      $error("arc_adc_result_clk: CONV_LEN out of range");
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Returns {hit, pair, high_half} for the four result registers
   function automatic logic [2:0] res_decode(input logic [31:0] a);
      logic [2:0] r;
      r = 3'h0;
      if (a == arc_pkg::IDX_RES_LO_26) begin
         r = 3'b100;
      end else if (a == arc_pkg::IDX_RES_HI_26) begin
         r = 3'b101;
      end else if (a == arc_pkg::IDX_RES_LO_37) begin
         r = 3'b110;
      end else if (a == arc_pkg::IDX_RES_HI_37) begin
         r = 3'b111;
      end
      return r;
   endfunction

   logic [2:0] dec_now;
   logic [2:0] dec_held_q;
   logic [31:0] addr_q;
   logic rd_q;
   logic wr_q;
   logic [7:0] wdat_q;
   logic lane0_q;

   // Decode of the live address, used at the capture edge
   assign dec_now = res_decode(avs_address_i);

   // ----------------------------------------------------------------
   // Bus handshake state
   // ----------------------------------------------------------------
   arc_pkg::arc_bus_e bus_q;
   arc_pkg::arc_bus_e bus_d;
   logic wait_q;
   logic [31:0] rdata_q;
   wire logic req = avs_read_i | avs_write_i;
   wire logic ack = (bus_q == arc_pkg::ARC_BUS_ACK);
   wire logic ack_rd = ack & rd_q;
   wire logic ack_wr = ack & wr_q & lane0_q;

   // Three phases: capture, memory look-up, answer
   always_comb begin
      bus_d = bus_q;
      unique case (bus_q)
         arc_pkg::ARC_BUS_IDLE: begin
            if (req) begin
               bus_d = arc_pkg::ARC_BUS_LOOK;
            end
         end
         arc_pkg::ARC_BUS_LOOK: begin
            bus_d = arc_pkg::ARC_BUS_ACK;
         end
         arc_pkg::ARC_BUS_ACK: begin
            bus_d = arc_pkg::ARC_BUS_IDLE;
         end
         default: begin
            bus_d = arc_pkg::ARC_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bus_q <= arc_pkg::ARC_BUS_IDLE;
      end else begin
         bus_q <= bus_d;
      end
   end

   // Request is held by the master, so sample it once at capture
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         addr_q <= 32'h0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         wdat_q <= 8'h00;
         lane0_q <= 1'b0;
         dec_held_q <= 3'h0;
      end else if (bus_q == arc_pkg::ARC_BUS_IDLE && req) begin
         addr_q <= avs_address_i;
         rd_q <= avs_read_i;
         wr_q <= avs_write_i;
         wdat_q <= avs_writedata_i[7:0];
         lane0_q <= avs_byteenable_i[0];
         dec_held_q <= dec_now;
      end
   end

   // ----------------------------------------------------------------
   // Conversion clock select and divider
   // ----------------------------------------------------------------
   logic [1:0] clk_sel_q;
   logic [1:0] div_cnt_q;
   logic [1:0] div_half;
   logic conv_clk_q;
   wire logic sel_wr = ack_wr & (addr_q == arc_pkg::IDX_CLK_SEL);
   wire logic div_end = (div_cnt_q == div_half);
   wire logic conv_tick = div_end & ~conv_clk_q;

   // Half period minus one in system clocks; reserved code runs as /8
   assign div_half = (clk_sel_q == arc_pkg::ARC_DIV2) ? 2'd0 :
                     (clk_sel_q == arc_pkg::ARC_DIV4) ? 2'd1 : 2'd3;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         clk_sel_q <= arc_pkg::CLK_SEL_RST;
      end else if (sel_wr) begin
         clk_sel_q <= wdat_q[1:0];
      end
   end

   // Free-running divider; a select change mid-conversion is undefined
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_cnt_q <= 2'd0;
         conv_clk_q <= 1'b0;
      end else if (div_end || div_cnt_q > div_half) begin
         div_cnt_q <= 2'd0;
         conv_clk_q <= ~conv_clk_q;
      end else begin
         div_cnt_q <= div_cnt_q + 2'd1;
      end
   end

   // ----------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------
   logic busy_q;
   logic pair_q;
   logic [CW-1:0] conv_cnt_q;
   wire logic start_wr = ack_wr & (addr_q == arc_pkg::IDX_CONV_CTRL)
                         & wdat_q[arc_pkg::FLD_START];
   wire logic last_tick = conv_tick &
                          (conv_cnt_q == CW'(CONV_LEN - 1));
   wire logic capture = busy_q & last_tick & ~start_wr;

   // A new start aborts a running conversion and begins again
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy_q <= 1'b0;
         pair_q <= 1'b0;
         conv_cnt_q <= '0;
      end else if (start_wr) begin
         busy_q <= 1'b1;
         pair_q <= wdat_q[arc_pkg::FLD_PAIR];
         conv_cnt_q <= '0;
      end else if (busy_q && conv_tick) begin
         conv_cnt_q <= conv_cnt_q + CW'(1);
         if (last_tick) begin
            busy_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Result storage
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] res_rd;
   logic rd_pair;

   // Memory address follows the incoming request while idle, so the
   // registered word is settled by the edge that builds the answer.
   // Limitation: a capture on the request's own capture edge still
   // reads back the previous word of that pair.
   assign rd_pair = (bus_q == arc_pkg::ARC_BUS_IDLE) ? dec_now[1] :
                    dec_held_q[1];

   arc_result_store #(
      .WIDTH(DATA_W),
      .DEPTH(arc_pkg::PAIR_COUNT)
   ) u_store (
      .clk_i(mclk_i),
      .wr_en_i(capture),
      .wr_addr_i(pair_q),
      .wr_data_i(sar_data_i),
      .rd_addr_i(rd_pair),
      .rd_data_o(res_rd)
   );

   // ----------------------------------------------------------------
   // Stored flags
   // ----------------------------------------------------------------
   logic [1:0] flag_q;
   logic [1:0] flag_d;
   wire logic rd_res = ack_rd & dec_held_q[2];

   // A capture in the clearing cycle keeps the flag set
   for (genvar p = 0; p < 2; p++) begin : g_flag
      assign flag_d[p] = (capture && pair_q == p[0]) ? 1'b1 :
                         (rd_res && dec_held_q[1] == p[0]) ? 1'b0 :
                         flag_q[p];
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flag_q <= 2'b00;
      end else begin
         flag_q <= flag_d;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   logic [1:0] stat_q;
   logic [1:0] stat_d;
   logic [1:0] mask_q;
   logic irq_q;
   logic [1:0] done_evt;
   wire logic stat_rd = ack_rd & (addr_q == arc_pkg::IDX_IRQ_STAT);
   wire logic mask_wr = ack_wr & (addr_q == arc_pkg::IDX_IRQ_MASK);

   assign done_evt = {capture & pair_q, capture & ~pair_q};
   // Read clears, but a new event in that cycle survives
   assign stat_d = done_evt | (stat_rd ? 2'b00 : stat_q);

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stat_q <= 2'b00;
         mask_q <= arc_pkg::IRQ_MASK_RST;
         irq_q <= 1'b0;
      end else begin
         stat_q <= stat_d;
         if (mask_wr) begin
            mask_q <= wdat_q[1:0];
         end
         irq_q <= |(stat_d & (mask_wr ? wdat_q[1:0] : mask_q));
      end
   end

   // ----------------------------------------------------------------
   // Read data selection
   // ----------------------------------------------------------------
   logic [7:0] lo_val;
   logic [7:0] hi_val;
   logic [7:0] rd_mux;
   wire logic flag_sel = dec_held_q[1] ? flag_q[1] : flag_q[0];

   assign hi_val = res_rd[9:2];
   assign lo_val = {res_rd[1:0], arc_pkg::LO_FILL, flag_sel};

   // Writes to result addresses fall through to nothing
   assign rd_mux =
      dec_held_q[2] ? (dec_held_q[0] ? hi_val : lo_val) :
      (addr_q == arc_pkg::IDX_CLK_SEL) ? {6'h00, clk_sel_q} :
      (addr_q == arc_pkg::IDX_CONV_CTRL) ? {6'h00, pair_q, busy_q} :
      (addr_q == arc_pkg::IDX_IRQ_STAT) ? {6'h00, stat_q} :
      (addr_q == arc_pkg::IDX_IRQ_MASK) ? {6'h00, mask_q} :
      arc_pkg::UNMAPPED_DATA;

   // Answer flops: wait drops for exactly the answer cycle
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0;
      end else if (bus_q == arc_pkg::ARC_BUS_LOOK) begin
         wait_q <= 1'b0;
         rdata_q <= rd_q ? {24'h0, rd_mux} : 32'h0;
      end else begin
         wait_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Every output is a flop copied out unchanged
   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = wait_q;
   assign conv_clk_o = conv_clk_q;
   assign conv_busy_o = busy_q;
   assign irq_o = irq_q;

endmodule // arc_adc_result_clk

// file: testbench/arc_adc_result_clk_asserts.sv
// Assertion checker for the converter result and clock select block
`timescale 1ns/1ps
module arc_asserts #(
   parameter int CONV_LEN = 86
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic [31:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic conv_clk_o,
   input wire logic conv_busy_o,
   input wire logic irq_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   // ----------------------------------------------------------------
   // Helper tracking of writes and of the divided clock
   // ----------------------------------------------------------------
   logic clk_q, start_q;
   logic [1:0] sel_q, settle_q, mask_q, mask_old_q;
   logic [3:0] half_q;
   logic [7:0] cnt_q;
   wire ack_w = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   wire start_w = ack_w && avs_writedata_i[0]
      && avs_address_i == arc_pkg::IDX_CONV_CTRL;
   wire sel_w = ack_w && avs_address_i == arc_pkg::IDX_CLK_SEL;
   wire tog_w = conv_clk_o != clk_q;
   wire rise_w = conv_clk_o && !clk_q;
   wire lo_w = avs_address_i == arc_pkg::IDX_RES_LO_26
      || avs_address_i == arc_pkg::IDX_RES_LO_37;
   // Reserved code runs as divide by eight
   wire [3:0] half_w = (sel_q == 2'h0) ? 4'h1 : (sel_q == 2'h1) ? 4'h2 : 4'h4;
   // Settle count hides the ragged first periods after a select change
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {clk_q, start_q, sel_q, settle_q, half_q, cnt_q} <= '0;
      end else begin
         clk_q <= conv_clk_o;
         start_q <= start_w;
         sel_q <= sel_w ? avs_writedata_i[1:0] : sel_q;
         settle_q <= sel_w ? 2'h0 : settle_q + 2'(tog_w && settle_q != 2'h3);
         half_q <= tog_w ? 4'h1 : half_q + 4'h1;
         cnt_q <= (start_w || start_q) ? 8'h0 : cnt_q + 8'(rise_w && conv_busy_o);
      end
   end
   // Mask copy, two deep to cover the registered interrupt
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {mask_q, mask_old_q} <= '0;
      end else begin
         mask_old_q <= mask_q;
         if (ack_w && avs_address_i == arc_pkg::IDX_IRQ_MASK) begin
            mask_q <= avs_writedata_i[1:0];
         end
      end
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   sequence s_answer;
      avs_waitrequest_o ##1 avs_waitrequest_o ##1 !avs_waitrequest_o;
   endsequence
   a_bus_latency: assert property (
      $rose(avs_read_i || avs_write_i) |-> s_answer)
      else $error("bus answer not two edges after request");
   a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low longer than one cycle");
   a_read_upper: assert property (avs_read_i && !avs_waitrequest_o
      |-> avs_readdata_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_low_fill: assert property (
      avs_read_i && !avs_waitrequest_o && lo_w
      |-> avs_readdata_o[5:1] == arc_pkg::LO_FILL)
      else $error("low result bits 5..1 not ones");
   a_busy_start: assert property (start_w |=> conv_busy_o)
      else $error("busy did not rise after start");
   a_conv_len: assert property (
      $fell(conv_busy_o) |-> rise_w && cnt_q == CONV_LEN - 1)
      else $error("conversion length wrong");
   a_div_ratio: assert property (
      tog_w && settle_q == 2'h3 |-> half_q == half_w)
      else $error("conversion clock ratio wrong");
   a_irq_masked: assert property (
      mask_q == 2'h0 && mask_old_q == 2'h0 |-> !irq_o)
      else $error("interrupt raised while fully masked");
endmodule // arc_asserts

bind arc_adc_result_clk arc_asserts #(.CONV_LEN(CONV_LEN)) u_arc_asserts (
   .mclk_i(mclk_i),
   .rst_b_i(rst_b_i),
   .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o),
   .conv_clk_o(conv_clk_o),
   .conv_busy_o(conv_busy_o),
   .irq_o(irq_o)
);

// file: testbench/arc_adc_result_clk_tb.sv
// Self-checking bench for the converter result and clock select block
`timescale 1ns/1ps
module arc_adc_result_clk_tb;
   // ----------------------------------------------------------------
   // Stimulus signals and bookkeeping
   // ----------------------------------------------------------------
   localparam int CONV_LEN = 4;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [31:0] avs_address_i = 32'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [9:0] sar_data_i = 10'h0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o, conv_clk_o, conv_busy_o, irq_o;
   int num_errors = 0;
   int samples_checked = 0;
   logic [31:0] lfsr_q = 32'hD7128E7F;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [31:0] hi, lo, a_lo;
   always #12.5 mclk_i = ~mclk_i;
   arc_adc_result_clk #(.DATA_W(10), .CONV_LEN(CONV_LEN)) u_arc_adc_result_clk (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o),
      .sar_data_i(sar_data_i),
      .conv_clk_o(conv_clk_o),
      .conv_busy_o(conv_busy_o),
      .irq_o(irq_o)
   );
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic end_of_test;
      if (num_errors == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] ex);
      samples_checked++;
      if (got !== ex) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, ex);
      end
   endtask
   // Request held until the edge that sees waitrequest low
   task automatic bus(input logic w, input logic [31:0] a, wd, ex, mk);
      @(posedge mclk_i);
      if (!w) begin
         exp_q.push_back(ex);
         msk_q.push_back(mk);
      end
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_writedata_i <= wd;
      do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, ex, mk);
      bus(1'b0, a, 32'h0, ex, mk);
   endtask
   task automatic wr(input logic [31:0] a, wd);
      bus(1'b1, a, wd, 32'h0, 32'h0);
   endtask
   // Start a conversion and wait, bounded, for the result to land
   task automatic convert(input logic pair);
      lfsr_q = lfsr_next(lfsr_q);
      sar_data_i <= lfsr_q[9:0];
      hi = {24'h0, lfsr_q[9:2]};
      lo = {24'h0, lfsr_q[1:0], 5'h1F, 1'b1};
      wr(arc_pkg::IDX_CONV_CTRL, {30'h0, pair, 1'b1});
      @(posedge mclk_i);
      for (int t = 0; t < 200 && conv_busy_o !== 1'b0; t++) @(posedge mclk_i);
      if (conv_busy_o !== 1'b0) num_errors++;
      repeat (3) @(posedge mclk_i);
   endtask
   // Monitor takes the oldest expected read off the queue
   always @(posedge mclk_i) begin
      if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0) begin
         check(avs_readdata_o & msk_q.pop_front(), exp_q.pop_front());
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      @(posedge mclk_i);
      rd(arc_pkg::IDX_CLK_SEL, 32'h0, 32'h3);
      rd(32'hFFFFF3FF, 32'h0, '1);
      wr(arc_pkg::IDX_IRQ_MASK, 32'h3);
      for (int k = 0; k < 4; k++) begin
         wr(arc_pkg::IDX_CLK_SEL, 32'(k));
         rd(arc_pkg::IDX_CLK_SEL, 32'(k), 32'h3);
         convert(k[0]);
         check({31'h0, irq_o}, 32'h1);
         rd(arc_pkg::IDX_IRQ_STAT, 32'h1 << k[0], 32'h3);
         repeat (2) @(posedge mclk_i);
         check({31'h0, irq_o}, 32'h0);
         a_lo = k[0] ? arc_pkg::IDX_RES_LO_37 : arc_pkg::IDX_RES_LO_26;
         if (k[1]) begin
            rd(a_lo + 32'h1, hi, '1);
            lo[0] = 1'b0;
         end
         rd(a_lo, lo, '1);
         rd(a_lo, lo & ~32'h1, '1);
         wr(a_lo + 32'h1, 32'h0);
         wr(a_lo, 32'h0);
         rd(a_lo + 32'h1, hi, '1);
         rd(a_lo, lo & ~32'h1, '1);
      end
      // Masked event still records status but keeps the line low
      wr(arc_pkg::IDX_IRQ_MASK, 32'h0);
      wr(arc_pkg::IDX_CLK_SEL, 32'h1);
      convert(1'b0);
      check({31'h0, irq_o}, 32'h0);
      rd(arc_pkg::IDX_IRQ_STAT, 32'h1, 32'h3);
      rd(arc_pkg::IDX_RES_LO_26, lo, '1);
      end_of_test();
   end
   // Watchdog sized well past the longest expected run
   initial begin
      #500000;
      num_errors++;
      end_of_test();
   end
endmodule // arc_adc_result_clk_tb
